// ### hw/cdr_pkg.sv
// Package: register map, field positions, reset values and timing for the vendor registers
package cdr_pkg;
  // Register addresses (ULPI immediate address space)
  localparam logic [5:0] ADDR_CHG_DET     = 6'h32;
  localparam logic [5:0] ADDR_HEADSET     = 6'h33;
  localparam logic [5:0] ADDR_IDCONV_WR   = 6'h36;
  localparam logic [5:0] ADDR_IDCONV_SET  = 6'h37;
  localparam logic [5:0] ADDR_IDCONV_CLR  = 6'h38;
  localparam logic [5:0] ADDR_CK_LATCH    = 6'h21;
  localparam logic [5:0] ADDR_VENDOR_LO   = 6'h30;
  localparam logic [5:0] ADDR_VENDOR_HI   = 6'h3f;
  // Charger detection field positions
  localparam int CHG_SRC_BIT   = 0;
  localparam int CHG_SINK_BIT  = 1;
  localparam int CHG_DP_BIT    = 2;
  localparam int CHG_ROLE_BIT  = 3;
  localparam int CHG_DET_BIT   = 4;
  // Headset key value
  localparam logic [3:0] HEADSET_KEY = 4'ha;
  // ID conversion field positions
  localparam int IDC_DONE_BIT  = 3;
  localparam int IDC_START_BIT = 4;
  localparam int IDC_IRQ_BIT   = 6;
  localparam int CK_IDC_LATCH_BIT = 3;
  // Reset values
  localparam logic [3:0] CHG_RST     = 4'h0;
  localparam logic [3:0] HEADSET_RST = 4'h0;
  localparam logic [2:0] IDCODE_RST  = 3'h0;
  // Conversion time
  localparam int CLK_MHZ        = 125;
  localparam int CONV_TIME_US   = 282;
  localparam int CONV_CYCLES    = CONV_TIME_US * CLK_MHZ;
  localparam int CONV_CW        = 16;
  // ULPI command codes (upper two bits of the command byte)
  localparam logic [1:0] CMD_REG_WR = 2'h2;
  localparam logic [1:0] CMD_REG_RD = 2'h3;

  // Access request from the ULPI command decoder
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [5:0] addr;
    logic [7:0] wdata;
  } cdr_req_t;

  // Analog control outputs
  typedef struct packed {
    logic dp_volt_src;
    logic dm_volt_src;
    logic dp_sink;
    logic dm_sink;
    logic dp_contact_src;
    logic dm_contact_src;
    logic dp_comp_sel;
    logic headset_en;
  } cdr_analog_t;
endpackage : cdr_pkg

// ### hw/cdr_conv_timer.sv
// Conversion timer: counts the ID resistor conversion time and flags completion
`timescale 1ns/1ns
`default_nettype none
module cdr_conv_timer #(
  parameter int CYCLES = cdr_pkg::CONV_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  typedef struct packed {
    logic [cdr_pkg::CONV_CW-1:0] cnt;
    logic                        busy;
    logic                        done;
  } cdr_tmr_t;

  cdr_tmr_t s;
  cdr_tmr_t next_s;

  // Counter runs from start until the full conversion time has passed
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (s.busy) begin
      if (s.cnt == cdr_pkg::CONV_CW'(CYCLES - 1)) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        next_s.cnt  = '0;
      end else begin
        next_s.cnt = s.cnt + 1'b1;
      end
    end else if (start) begin
      next_s.busy = 1'b1;
      next_s.cnt  = '0;
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign done = s.done;

  conv_len_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(s.busy) |-> s.busy [*8]) // [R8]
    else $error("conversion ended too early");
endmodule : cdr_conv_timer
`default_nettype wire

// ### hw/cdr_regs.sv
// Vendor register bank: charger detection, headset key and ID resistor conversion
//
// Overview of operation
// [R1] Bits 0..2 enable voltage source, sink with comparator, DP contact source.
// [R2] Bit 3 selects role: portable device or charging host port.
// [R3] Charging host role swaps source, sink, contact and comparator between DP and DM.
// [R4] Bit 4 reads one only with comparator high and line state 00.
// [R5] Link should clear bits 2:0 before USB operation.
// [R6] Headset audio enabled only while key field equals 1010.
// [R7] Result field 2:0 carries the resistor code from the converter.
// [R8] Complete flag sets when the 282 us conversion ends.
// [R9] Reading the conversion register clears the complete flag.
// [R10] Reading result via carkit status leaves complete flags alone.
// [R11] Start bit launches conversion on write or set, clears at completion.
// [R12] Conversion register read at 36h-38h; write 36h, set 37h, clear 38h.
// [R13] Enabled completion raises the alternate interrupt indication.
// [R14] Effective interrupt enable is OR of local and carkit enable bits.
// [R15] Link keeps bit 5 of the conversion register at zero.
// [R16] Vendor registers 30h-3Fh use immediate register commands.
// [R17] Carkit latch bit sets on enabled rising complete flag, clears on read.
// [R18] Set access sets bits written as one; clear access clears them.
// [R19] Reserved bits read zero and ignore writes.
`timescale 1ns/1ns
`default_nettype none
module cdr_regs (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire cdr_pkg::cdr_req_t req,
  input  wire logic              cmd_immediate,
  input  wire logic [1:0]        line_state,
  input  wire logic              comparator_raw,
  input  wire logic [2:0]        id_adc_code,
  input  wire logic              carkit_id_irq_en,
  input  wire logic              carkit_status_rd,
  output logic [7:0]             rdata,
  output logic                   rvalid,
  output logic                   alt_int,
  output cdr_pkg::cdr_analog_t   analog
);
  typedef struct packed {
    logic [3:0]           chg;
    logic [3:0]           headset_key;
    logic [2:0]           id_code;
    logic                 id_done;
    logic                 id_launch;
    logic                 id_irq_en;
    logic                 irq_latch;
    logic [7:0]           rdata;
    logic                 rvalid;
    logic                 alt_int;
    cdr_pkg::cdr_analog_t analog;
  } cdr_state_t;

  cdr_state_t s;
  cdr_state_t next_s;
  logic       conv_busy;
  logic       conv_done;
  logic       start_pulse;
  logic       acc;
  logic       det;
  logic       irq_en_eff;
  logic [7:0] idc_word;
  logic [7:0] new_idc;

  // Only immediate commands reach the vendor registers
  assign acc = req.valid && cmd_immediate; // [R16]

  // Detector: comparator gated by sink enable and idle line state
  assign det = comparator_raw && s.chg[cdr_pkg::CHG_SINK_BIT] && (line_state == 2'h0); // [R1] [R4]

  // Combined interrupt enable
  assign irq_en_eff = s.id_irq_en || carkit_id_irq_en; // [R14]

  // Readback image of the conversion register, reserved bits zero
  assign idc_word = {1'b0, s.id_irq_en, 1'b0, s.id_launch, s.id_done, s.id_code}; // [R19]

  // Next value of the conversion register after a write, set or clear
  always_comb begin
    new_idc = idc_word;
    if (acc && req.write) begin
      unique case (req.addr)
        cdr_pkg::ADDR_IDCONV_WR:  new_idc = req.wdata; // [R12]
        cdr_pkg::ADDR_IDCONV_SET: new_idc = idc_word | req.wdata; // [R18]
        cdr_pkg::ADDR_IDCONV_CLR: new_idc = idc_word & ~req.wdata; // [R18]
        default:                  new_idc = idc_word;
      endcase
    end
  end

  // Launch when the start bit goes from zero to one and no conversion runs
  // Starting only from idle keeps a second start from cutting a running conversion short
  assign start_pulse = new_idc[cdr_pkg::IDC_START_BIT] && !s.id_launch && !conv_busy; // [R11]

  cdr_conv_timer #(
    .CYCLES (cdr_pkg::CONV_CYCLES)
  ) u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .start    (start_pulse),
    .busy     (conv_busy),
    .done     (conv_done)
  );

  // Register updates, readback and side effects
  always_comb begin
    next_s        = s;
    next_s.rvalid = 1'b0;
    if (acc && req.write) begin
      unique case (req.addr)
        cdr_pkg::ADDR_CHG_DET: next_s.chg = req.wdata[3:0]; // [R1] [R2] [R19]
        cdr_pkg::ADDR_HEADSET: next_s.headset_key = req.wdata[3:0]; // [R6]
        default: ;
      endcase
      next_s.id_launch = new_idc[cdr_pkg::IDC_START_BIT]; // [R11]
      next_s.id_irq_en = new_idc[cdr_pkg::IDC_IRQ_BIT];
    end
    if (acc && !req.write) begin
      next_s.rvalid = 1'b1;
      unique case (req.addr)
        cdr_pkg::ADDR_CHG_DET: next_s.rdata = {3'h0, det, s.chg}; // [R4] [R19]
        cdr_pkg::ADDR_HEADSET: next_s.rdata = {4'h0, s.headset_key}; // [R6]
        cdr_pkg::ADDR_IDCONV_WR, cdr_pkg::ADDR_IDCONV_SET, cdr_pkg::ADDR_IDCONV_CLR: begin
          next_s.rdata   = idc_word; // [R12]
          next_s.id_done = 1'b0; // [R9]
        end
        cdr_pkg::ADDR_CK_LATCH: begin
          next_s.rdata     = {4'h0, s.irq_latch, 3'h0};
          next_s.irq_latch = 1'b0; // [R17]
        end
        default: next_s.rdata = 8'h00;
      endcase
    end
    // Completion: result captured, flag set (wins over read clear), start cleared
    next_s.alt_int = 1'b0;
    if (conv_done) begin
      next_s.id_code   = id_adc_code; // [R7]
      next_s.id_done   = 1'b1; // [R8]
      next_s.id_launch = 1'b0; // [R11]
      if (irq_en_eff && !s.id_done) begin
        next_s.irq_latch = 1'b1; // [R17]
      end
      if (irq_en_eff) begin
        next_s.alt_int = 1'b1; // [R13]
      end
    end
    // Carkit status read path has no effect on the flag
    if (carkit_status_rd) begin
      next_s.id_done = next_s.id_done; // [R10]
    end
    // Analog steering, swapped in charging host role
    if (s.chg[cdr_pkg::CHG_ROLE_BIT]) begin // [R2] [R3]
      next_s.analog.dp_volt_src    = 1'b0;
      next_s.analog.dm_volt_src    = s.chg[cdr_pkg::CHG_SRC_BIT];
      next_s.analog.dp_sink        = 1'b0;
      next_s.analog.dm_sink        = s.chg[cdr_pkg::CHG_SINK_BIT];
      next_s.analog.dp_contact_src = 1'b0;
      next_s.analog.dm_contact_src = s.chg[cdr_pkg::CHG_DP_BIT];
      next_s.analog.dp_comp_sel    = 1'b0;
    end else begin
      next_s.analog.dp_volt_src    = s.chg[cdr_pkg::CHG_SRC_BIT]; // [R1]
      next_s.analog.dm_volt_src    = 1'b0;
      next_s.analog.dp_sink        = s.chg[cdr_pkg::CHG_SINK_BIT];
      next_s.analog.dm_sink        = 1'b0;
      next_s.analog.dp_contact_src = s.chg[cdr_pkg::CHG_DP_BIT];
      next_s.analog.dm_contact_src = 1'b0;
      next_s.analog.dp_comp_sel    = 1'b1;
    end
    next_s.analog.headset_en = (s.headset_key == cdr_pkg::HEADSET_KEY); // [R6]
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdata   = s.rdata;
  assign rvalid  = s.rvalid;
  assign alt_int = s.alt_int;
  assign analog  = s.analog;

  // Assertions
  det_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc && !req.write && req.addr == cdr_pkg::ADDR_CHG_DET && line_state != 2'h0)
      |=> !rdata[cdr_pkg::CHG_DET_BIT]) // [R4]
    else $error("detect bit high with active line state");
  sink_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc && !req.write && req.addr == cdr_pkg::ADDR_CHG_DET && !s.chg[1])
      |=> rdata[4:0] == {1'b0, s.chg}) // [R1]
    else $error("comparator reads one with sink off");
  headset_key_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    ##1 analog.headset_en == ($past(s.headset_key) == 4'ha)) // [R6]
    else $error("headset enable mismatch");
  role_swap_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $past(s.chg[3]) |-> !analog.dp_volt_src && !analog.dp_sink && !analog.dp_contact_src) // [R3]
    else $error("host role left DP driven");
  done_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    conv_done |=> s.id_done && !s.id_launch) // [R8]
    else $error("completion not reflected");
  done_clr_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc && !req.write && req.addr == cdr_pkg::ADDR_IDCONV_SET && !conv_done) |=> !s.id_done) // [R9]
    else $error("read did not clear complete flag");
  launch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (acc && req.write && req.addr == cdr_pkg::ADDR_IDCONV_SET && req.wdata[4] && !s.id_launch
      && !conv_busy) |=> conv_busy && s.id_launch) // [R11]
    else $error("set access did not launch conversion");
  irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (conv_done && (s.id_irq_en || carkit_id_irq_en)) |=> alt_int) // [R13] [R14]
    else $error("interrupt not raised");
  reserved_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    rvalid && $past(req.addr) == cdr_pkg::ADDR_HEADSET |-> rdata[7:4] == 4'h0) // [R19]
    else $error("reserved bits read nonzero");
  latch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (conv_done && irq_en_eff && !s.id_done) |=> s.irq_latch) // [R17]
    else $error("carkit latch not set");


  // Register writes land in the addressed field only
  chg_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R1] [R2]
    (acc && req.write && req.addr == cdr_pkg::ADDR_CHG_DET)
      |=> s.chg == $past(req.wdata[3:0]))
    else $error("charger control write lost");
  key_write_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R6]
    (acc && req.write && req.addr == cdr_pkg::ADDR_HEADSET)
      |=> s.headset_key == $past(req.wdata[3:0]))
    else $error("headset key write lost");
  cmd_filter_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R16]
    (req.valid && !cmd_immediate)
      |=> !rvalid && $stable(s.chg) && $stable(s.headset_key) && $stable(s.id_irq_en))
    else $error("non-immediate command reached the registers");

  // Read answers come one cycle after an accepted read, never otherwise
  read_answer_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R12] [R16]
    (acc && !req.write) |=> rvalid)
    else $error("read not answered");
  rvalid_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R16]
    rvalid |-> $past(acc) && !$past(req.write))
    else $error("answer without an accepted read");
  chg_resv_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R19]
    (rvalid && $past(req.addr) == cdr_pkg::ADDR_CHG_DET) |-> rdata[7:5] == 3'h0)
    else $error("charger reserved bits read nonzero");
  idc_resv_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R19]
    (rvalid && $past(req.addr) >= cdr_pkg::ADDR_IDCONV_WR
      && $past(req.addr) <= cdr_pkg::ADDR_IDCONV_CLR)
      |-> !rdata[7] && !rdata[5])
    else $error("conversion reserved bits read nonzero");

  // Bit set and bit clear accesses touch only the bits written as one
  set_keeps_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R18]
    (acc && req.write && req.addr == cdr_pkg::ADDR_IDCONV_SET)
      |=> s.id_irq_en == ($past(s.id_irq_en) || $past(req.wdata[cdr_pkg::IDC_IRQ_BIT])))
    else $error("set access disturbed interrupt enable");
  clr_access_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R18]
    (acc && req.write && req.addr == cdr_pkg::ADDR_IDCONV_CLR)
      |=> s.id_irq_en == ($past(s.id_irq_en) && !$past(req.wdata[cdr_pkg::IDC_IRQ_BIT])))
    else $error("clear access disturbed interrupt enable");

  // Completion side effects and flag keeping
  code_cap_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R7]
    conv_done |=> s.id_code == $past(id_adc_code))
    else $error("resistor code not captured");
  irq_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R13] [R14]
    alt_int |-> $past(conv_done) && $past(irq_en_eff))
    else $error("interrupt without enabled completion");
  carkit_keep_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R10]
    (carkit_status_rd && !acc && !conv_done) |=> $stable(s.id_done))
    else $error("carkit status read changed complete flag");
  latch_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R17]
    (acc && !req.write && req.addr == cdr_pkg::ADDR_CK_LATCH && !conv_done) |=> !s.irq_latch)
    else $error("carkit latch not cleared by read");

  // Analog steering per role, one cycle behind the control bits
  device_route_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R1] [R2]
    ($past(rst_n) && !$past(s.chg[cdr_pkg::CHG_ROLE_BIT]))
      |-> analog.dp_volt_src == $past(s.chg[cdr_pkg::CHG_SRC_BIT])
        && analog.dp_sink == $past(s.chg[cdr_pkg::CHG_SINK_BIT])
        && analog.dp_contact_src == $past(s.chg[cdr_pkg::CHG_DP_BIT])
        && analog.dp_comp_sel)
    else $error("device role routing wrong");
  host_route_a: assert property (@(posedge core_clk) disable iff (!rst_n) // [R3]
    $past(s.chg[cdr_pkg::CHG_ROLE_BIT])
      |-> analog.dm_volt_src == $past(s.chg[cdr_pkg::CHG_SRC_BIT])
        && analog.dm_sink == $past(s.chg[cdr_pkg::CHG_SINK_BIT])
        && analog.dm_contact_src == $past(s.chg[cdr_pkg::CHG_DP_BIT])
        && !analog.dp_comp_sel)
    else $error("host role routing not swapped");

  // Cover points for the main scenarios
  conv_c:   cover property (@(posedge core_clk) disable iff (!rst_n) conv_done);
  irq_c:    cover property (@(posedge core_clk) disable iff (!rst_n) alt_int);
  hs_c:     cover property (@(posedge core_clk) disable iff (!rst_n) analog.headset_en);
  launch_c: cover property (@(posedge core_clk) disable iff (!rst_n) start_pulse);
  latch_c:  cover property (@(posedge core_clk) disable iff (!rst_n) s.irq_latch);
endmodule : cdr_regs
`default_nettype wire

// ### sim/cdr_link_model.sv
// Link controller model: issues immediate and non-immediate register accesses and notes expected read data
`timescale 1ns/1ns
`default_nettype none
module cdr_link_model (
  input  wire logic             core_clk,
  output var cdr_pkg::cdr_req_t req,
  output var logic              cmd_immediate
);
  logic [7:0] exp_q[$];

  // Idle bus at time zero
  initial begin
    req = '0;
    cmd_immediate = 1'b0;
  end

  // One-cycle access pulse, raised and dropped at falling edges
  task automatic access(input logic wr, input logic [5:0] a, input logic [7:0] d,
                        input logic imm);
    @(negedge core_clk);
    req = '{1'b1, wr, a, d};
    cmd_immediate = imm;
    @(negedge core_clk);
    req = '{1'b0, 1'b0, ~a, ~d};
    cmd_immediate = 1'b0;
  endtask : access

  // Write or set or clear; bit 5 of the conversion register is kept low
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic imm);
    if (a >= 6'h36 && a <= 6'h38) d[5] = 1'b0;
    access(1'b1, a, d, imm);
  endtask : wr

  // Read, noting the expected byte first
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    access(1'b0, a, 8'h00, 1'b1);
  endtask : rd
endmodule : cdr_link_model
`default_nettype wire

// ### sim/tb_cdr_regs.sv
// Testbench for the vendor register bank
`timescale 1ns/1ns
`default_nettype none
module tb_cdr_regs;
  logic                 core_clk;
  logic                 rst_n;
  cdr_pkg::cdr_req_t    req;
  logic                 cmd_immediate;
  logic [1:0]           line_state;
  logic                 comparator_raw;
  logic [2:0]           id_adc_code;
  logic                 carkit_id_irq_en;
  logic                 carkit_status_rd;
  logic [7:0]           rdata;
  logic                 rvalid;
  logic                 alt_int;
  cdr_pkg::cdr_analog_t analog;
  int                   error_cnt = 0;
  int                   checked = 0;
  logic [7:0]           irq_cnt = 8'h00;
  logic [7:0]           d;
  logic [3:0]           chg;
  logic                 hs;
  logic [2:0]           code;
  int                   seed;
  logic [2:0]           codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};

  cdr_link_model u_cdr_link_model (.core_clk(core_clk), .req(req), .cmd_immediate(cmd_immediate));
  cdr_regs u_cdr_regs (.core_clk(core_clk), .rst_n(rst_n), .req(req),
    .cmd_immediate(cmd_immediate), .line_state(line_state), .comparator_raw(comparator_raw),
    .id_adc_code(id_adc_code), .carkit_id_irq_en(carkit_id_irq_en),
    .carkit_status_rd(carkit_status_rd), .rdata(rdata), .rvalid(rvalid), .alt_int(alt_int),
    .analog(analog));

  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic conclude;
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  // Analog routing expected from control bits and headset key
  function automatic logic [7:0] ana(input logic [3:0] c, input logic h);
    ana = {c[0] & ~c[3], c[0] & c[3], c[1] & ~c[3], c[1] & c[3], c[2] & ~c[3], c[2] & c[3],
           ~c[3], h};
  endfunction : ana

  // Clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Read monitor takes the oldest note for each answer
  always @(negedge core_clk) begin
    if (rvalid === 1'b1) begin
      if (u_cdr_link_model.exp_q.size() == 0) check(rdata, ~rdata);
      else check(rdata, u_cdr_link_model.exp_q.pop_front());
    end
  end

  // Count interrupt pulses, sampled mid-cycle where the pulse is settled
  always @(negedge core_clk) begin
    if (alt_int === 1'b1) irq_cnt <= irq_cnt + 8'h01;
  end

  // Watchdog
  initial begin
    #(45000 * 8);
    error_cnt++;
    conclude();
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    line_state = 2'h0;
    comparator_raw = 1'b0;
    id_adc_code = 3'h0;
    carkit_id_irq_en = 1'b0;
    carkit_status_rd = 1'b0;
    hs = 1'b0;
    seed = $urandom(47);
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    foreach (codes[i]) if (i < 4) u_cdr_link_model.rd({4'h3, 2'(i)} + 6'h1, 8'h00);
    u_cdr_link_model.rd(6'h36, 8'h00);
    u_cdr_link_model.rd(6'h21, 8'h00);
    // Charger controls, role swap and detection gating
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom);
      line_state = 2'($urandom);
      comparator_raw = 1'($urandom);
      chg = d[3:0];
      u_cdr_link_model.wr(6'h32, d, 1'b1);
      u_cdr_link_model.rd(6'h32, {3'h0, chg[1] & comparator_raw & (line_state == 2'h0), chg});
      repeat (3) @(negedge core_clk);
      check(analog, ana(chg, hs));
    end
    // Headset key, with ignored non-immediate writes
    for (int i = 0; i < 8; i++) begin
      d = i[0] ? 8'hfa : 8'($urandom);
      u_cdr_link_model.wr(6'h33, d, 1'b1);
      u_cdr_link_model.wr(6'h33, ~d, 1'b0);
      hs = (d[3:0] == 4'ha);
      u_cdr_link_model.rd(6'h33, {4'h0, d[3:0]});
      repeat (3) @(negedge core_clk);
      check(analog, ana(chg, hs));
    end
    u_cdr_link_model.rd(6'h3f, 8'h00);
    u_cdr_link_model.wr(6'h32, 8'h00, 1'b1);
    // ID conversion: write, set, clear, completion and flags
    code = codes[$urandom % 7];
    id_adc_code = code;
    u_cdr_link_model.wr(6'h36, 8'hc0, 1'b1);
    u_cdr_link_model.rd(6'h36, 8'h40);
    u_cdr_link_model.wr(6'h37, 8'h30, 1'b1);
    u_cdr_link_model.rd(6'h37, 8'h50);
    u_cdr_link_model.wr(6'h38, 8'h40, 1'b1);
    u_cdr_link_model.rd(6'h38, 8'h10);
    carkit_id_irq_en = 1'b1;
    for (int n = 0; n < 36000 && irq_cnt == 8'h00; n++) @(negedge core_clk);
    repeat (4) @(negedge core_clk);
    check(irq_cnt, 8'h01);
    carkit_status_rd = 1'b1;
    @(negedge core_clk);
    carkit_status_rd = 1'b0;
    u_cdr_link_model.rd(6'h21, 8'h08);
    u_cdr_link_model.rd(6'h21, 8'h00);
    u_cdr_link_model.rd(6'h36, {5'h01, code});
    u_cdr_link_model.rd(6'h38, {5'h00, code});
    repeat (4) @(negedge core_clk);
    check(8'(u_cdr_link_model.exp_q.size()), 8'h00);
    conclude();
  end
endmodule : tb_cdr_regs
`default_nettype wire
